//--- mfcr_pkg.sv
// Functional notes
// [R1] bit 2 of settings one enables position detect timeout fault; resets 0
// [R2] bit 1 of settings one enables position detect frequency fault; resets 0
// [R3] bit 0 of settings one enables loop saturation indication; resets 0
// [R4] bit 30 of settings two enables overspeed lock detector; resets 0
// [R5] bit 29 of settings two enables back-emf lock detector; resets 0
// [R6] bit 28 of settings two enables motor absent lock detector; resets 0
// [R7] bits 27..25 pick overspeed threshold, 130% to 200% in 10% steps
// [R8] bits 24..22 pick back-emf threshold, 40..65, 67.5, 70 percent
// [R9] settings two is a 32-bit register at index 92h, resets to zero
// [R10] bit 31 of settings two is reserved, read/write, no effect
// [R11] writes land at the acknowledged edge; reads return stored bits verbatim
package mfcr_pkg;

  // register indices; byte address is four times the index
  localparam logic [9:0]  IDX_SETTINGS_ONE = 10'h091;
  localparam logic [9:0]  IDX_SETTINGS_TWO = 10'h092;
  localparam logic [9:0]  IDX_IRQ_STATUS   = 10'h0a0;
  localparam logic [9:0]  IDX_IRQ_CLEAR    = 10'h0a1;
  localparam logic [9:0]  IDX_IRQ_ENABLE   = 10'h0a2;

  // reset values
  localparam logic [31:0] RST_SETTINGS_TWO = 32'h00000000;
  localparam logic [2:0]  RST_SETTINGS_ONE = 3'h0;
  localparam logic [5:0]  RST_IRQ          = 6'h00;

  // field positions in settings one
  localparam int POS_TIMEOUT_EN = 2;
  localparam int POS_FREQ_EN    = 1;
  localparam int POS_SAT_EN     = 0;

  // interrupt event bit positions
  localparam int NUM_EVENTS      = 6;
  localparam int EV_TIMEOUT      = 0;
  localparam int EV_FREQUENCY    = 1;
  localparam int EV_OVERSPEED    = 2;
  localparam int EV_BACKEMF      = 3;
  localparam int EV_MOTOR_ABSENT = 4;
  localparam int EV_SATURATION   = 5;

  // bus geometry
  localparam int NUM_LANES = 4;
  localparam int LANE_BITS = 8;

  // overspeed threshold in percent of maximum speed, per code
  localparam logic [7:0] OVERSPEED_BASE_PCT = 8'h82;
  localparam logic [7:0] OVERSPEED_STEP_PCT = 8'h0a;

  // back-emf threshold in tenths of a percent, per code
  localparam logic [9:0] BACKEMF_PERMILLE [8] = '{
    10'h190, 10'h1c2, 10'h1f4, 10'h226, 10'h258, 10'h28a, 10'h2a3, 10'h2bc
  };

  // second fault settings register layout
  typedef struct packed {
    logic       reserved;
    logic       overspeed_lock_enable;
    logic       backemf_lock_enable;
    logic       motor_absent_lock_enable;
    logic [2:0] overspeed_threshold_select;
    logic [2:0] backemf_threshold_select;
    logic [21:0] lower_fields;
  } mfcr_settings_two_t;

  // first fault settings register, low three bits only
  typedef struct packed {
    logic position_detect_timeout_fault_enable;
    logic position_detect_frequency_fault_enable;
    logic saturation_indication_enable;
  } mfcr_settings_one_t;

  // decoded thresholds
  typedef struct packed {
    logic [7:0] overspeed_percent;
    logic [9:0] backemf_permille;
  } mfcr_thresholds_t;

endpackage

//--- mfcr_regs.sv
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/100ps
// fault and lock detection configuration registers with wishbone slave
module mfcr_regs
(
  input  wire logic                       sys_clk,
  input  wire logic                       rst,
  input  wire logic                       ce,
  // wishbone classic slave
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [11:0]                wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [31:0]                wb_dat_i,
  output logic      [31:0]                wb_dat_o,
  output logic                            wb_ack_o,
  // raw detector events from the motor control logic
  input  wire logic                       position_timeout_event,
  input  wire logic                       position_frequency_event,
  input  wire logic                       overspeed_event,
  input  wire logic                       backemf_event,
  input  wire logic                       motor_absent_event,
  input  wire logic                       loop_saturation,
  // configuration outputs
  output mfcr_pkg::mfcr_settings_one_t    settings_one,
  output mfcr_pkg::mfcr_settings_two_t    settings_two,
  output mfcr_pkg::mfcr_thresholds_t      thresholds,
  output logic                            saturation_indication,
  output logic                            irq
);

  // ---------------- bus decode ----------------
  logic [9:0]  word_index;
  logic        bus_request;
  logic        write_commit;
  logic        hit_one;
  logic        hit_two;
  logic        hit_status;
  logic        hit_clear;
  logic        hit_enable;
  logic        hit_any;
  logic [31:0] lane_mask;

  // address and strobe decode
  assign word_index   = wb_adr_i[11:2];
  assign bus_request  = wb_cyc_i & wb_stb_i;
  assign write_commit = bus_request & wb_we_i & wb_ack_o; // [R11]
  assign hit_one      = (word_index == mfcr_pkg::IDX_SETTINGS_ONE);
  assign hit_two      = (word_index == mfcr_pkg::IDX_SETTINGS_TWO); // [R9]
  assign hit_status   = (word_index == mfcr_pkg::IDX_IRQ_STATUS);
  assign hit_clear    = (word_index == mfcr_pkg::IDX_IRQ_CLEAR);
  assign hit_enable   = (word_index == mfcr_pkg::IDX_IRQ_ENABLE);
  assign hit_any      = hit_one | hit_two | hit_status | hit_clear | hit_enable;

  // expand byte selects to a bit mask
  genvar lane;
  generate
    for (lane = 0; lane < mfcr_pkg::NUM_LANES; lane++)
    begin : g_lane
      assign lane_mask[lane*mfcr_pkg::LANE_BITS +: mfcr_pkg::LANE_BITS] =
        {mfcr_pkg::LANE_BITS{wb_sel_i[lane]}};
    end
  endgenerate

  // ---------------- acknowledge ----------------
  logic next_ack;

  // one wait state, ack drops the cycle after it was given
  assign next_ack = bus_request & ~wb_ack_o;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      wb_ack_o <= 1'b0;
    else if (ce)
      wb_ack_o <= next_ack;
  end

  // ---------------- settings two ----------------
  logic [31:0] two_bits;
  logic [31:0] next_two_bits;

  // masked merge, every bit is stored including the reserved one
  assign next_two_bits = (hit_two & write_commit) ?
                         ((two_bits & ~lane_mask) | (wb_dat_i & lane_mask)) :
                         two_bits; // [R10] [R11]

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      two_bits <= mfcr_pkg::RST_SETTINGS_TWO; // [R9] [R4] [R5] [R6] [R7] [R8] [R10]
    else if (ce)
      two_bits <= next_two_bits;
  end

  assign settings_two = mfcr_pkg::mfcr_settings_two_t'(two_bits);

  // ---------------- settings one ----------------
  logic [2:0] one_bits;
  logic [2:0] next_one_bits;

  // low three bits live in byte lane zero
  assign next_one_bits = (hit_one & write_commit & wb_sel_i[0]) ?
                         wb_dat_i[2:0] : one_bits; // [R1] [R2] [R3]

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      one_bits <= mfcr_pkg::RST_SETTINGS_ONE; // [R1] [R2] [R3]
    else if (ce)
      one_bits <= next_one_bits;
  end

  assign settings_one.position_detect_timeout_fault_enable   =
    one_bits[mfcr_pkg::POS_TIMEOUT_EN]; // [R1]
  assign settings_one.position_detect_frequency_fault_enable =
    one_bits[mfcr_pkg::POS_FREQ_EN]; // [R2]
  assign settings_one.saturation_indication_enable           =
    one_bits[mfcr_pkg::POS_SAT_EN]; // [R3]

  // ---------------- saturation indication ----------------
  logic next_saturation_indication;

  // suppressed while the enable is low
  assign next_saturation_indication =
    loop_saturation & settings_one.saturation_indication_enable; // [R3]

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      saturation_indication <= 1'b0;
    else if (ce)
      saturation_indication <= next_saturation_indication;
  end

  // ---------------- gated events ----------------
  logic [mfcr_pkg::NUM_EVENTS-1:0] raw_events;
  logic [mfcr_pkg::NUM_EVENTS-1:0] event_gate;
  logic [mfcr_pkg::NUM_EVENTS-1:0] gated_events;

  // collect detector events in status bit order
  assign raw_events[mfcr_pkg::EV_TIMEOUT]      = position_timeout_event;
  assign raw_events[mfcr_pkg::EV_FREQUENCY]    = position_frequency_event;
  assign raw_events[mfcr_pkg::EV_OVERSPEED]    = overspeed_event;
  assign raw_events[mfcr_pkg::EV_BACKEMF]      = backemf_event;
  assign raw_events[mfcr_pkg::EV_MOTOR_ABSENT] = motor_absent_event;
  assign raw_events[mfcr_pkg::EV_SATURATION]   = loop_saturation;

  // a detector only reports while its enable is set
  assign event_gate[mfcr_pkg::EV_TIMEOUT]      =
    settings_one.position_detect_timeout_fault_enable; // [R1]
  assign event_gate[mfcr_pkg::EV_FREQUENCY]    =
    settings_one.position_detect_frequency_fault_enable; // [R2]
  assign event_gate[mfcr_pkg::EV_OVERSPEED]    = settings_two.overspeed_lock_enable; // [R4]
  assign event_gate[mfcr_pkg::EV_BACKEMF]      = settings_two.backemf_lock_enable; // [R5]
  assign event_gate[mfcr_pkg::EV_MOTOR_ABSENT] = settings_two.motor_absent_lock_enable; // [R6]
  assign event_gate[mfcr_pkg::EV_SATURATION]   =
    settings_one.saturation_indication_enable; // [R3]

  assign gated_events = raw_events & event_gate;

  // ---------------- interrupt registers ----------------
  logic [mfcr_pkg::NUM_EVENTS-1:0] irq_status;
  logic [mfcr_pkg::NUM_EVENTS-1:0] irq_enable;
  logic [mfcr_pkg::NUM_EVENTS-1:0] clear_hits;
  logic [mfcr_pkg::NUM_EVENTS-1:0] next_irq_enable;

  // write-one-to-clear strobes, lane zero only
  assign clear_hits = (hit_clear & write_commit & wb_sel_i[0]) ?
                      wb_dat_i[mfcr_pkg::NUM_EVENTS-1:0] : '0;

  assign next_irq_enable = (hit_enable & write_commit & wb_sel_i[0]) ?
                           wb_dat_i[mfcr_pkg::NUM_EVENTS-1:0] : irq_enable;

  // sticky status per event, a new event beats a clear
  genvar ev;
  generate
    for (ev = 0; ev < mfcr_pkg::NUM_EVENTS; ev++)
    begin : g_status
      logic next_bit;

      assign next_bit = gated_events[ev] | (irq_status[ev] & ~clear_hits[ev]);

      always_ff @(posedge sys_clk or posedge rst)
      begin
        if (rst)
          irq_status[ev] <= 1'b0;
        else if (ce)
          irq_status[ev] <= next_bit;
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      irq_enable <= mfcr_pkg::RST_IRQ;
    else if (ce)
      irq_enable <= next_irq_enable;
  end

  // level interrupt while any enabled status bit is set
  assign irq = |(irq_status & irq_enable);

  // ---------------- read data ----------------
  logic [31:0] read_word;
  logic [31:0] next_dat;

  // unmapped and write-only addresses read as zero
  assign read_word = hit_two    ? two_bits :
                     hit_one    ? {29'h0, one_bits} :
                     hit_status ? {26'h0, irq_status} :
                     hit_enable ? {26'h0, irq_enable} :
                     32'h00000000; // [R11]

  assign next_dat = (next_ack & ~wb_we_i & hit_any) ? read_word : 32'h00000000;

  // read data captured with the ack
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      wb_dat_o <= 32'h00000000;
    else if (ce)
      wb_dat_o <= next_dat;
  end

  // ---------------- threshold decode ----------------
  mfcr_threshold_decode u_decode
  (
    .sys_clk                    (sys_clk),
    .rst                        (rst),
    .ce                         (ce),
    .overspeed_threshold_select (settings_two.overspeed_threshold_select),
    .backemf_threshold_select   (settings_two.backemf_threshold_select),
    .thresholds                 (thresholds)
  );

endmodule

//--- mfcr_regs_asserts.sv
`timescale 1ns/100ps
// port-level checks of the fault settings register block
module mfcr_regs_asserts
(
  input wire logic                   sys_clk,
  input wire logic                   rst,
  input wire logic                   ce,
  input wire logic                   wb_cyc_i,
  input wire logic                   wb_stb_i,
  input wire logic                   wb_we_i,
  input wire logic [11:0]            wb_adr_i,
  input wire logic [3:0]             wb_sel_i,
  input wire logic [31:0]            wb_dat_i,
  input wire logic [31:0]            wb_dat_o,
  input wire logic                   wb_ack_o,
  input wire logic                   loop_saturation,
  input wire logic                   saturation_indication,
  input mfcr_pkg::mfcr_settings_one_t settings_one,
  input mfcr_pkg::mfcr_settings_two_t settings_two,
  input mfcr_pkg::mfcr_thresholds_t   thresholds
);
  // back-emf thresholds in tenths of a percent
  localparam logic [9:0] BEMF [8] = '{10'h190, 10'h1c2, 10'h1f4, 10'h226,
                                      10'h258, 10'h28a, 10'h2a3, 10'h2bc};
  wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o && ce;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  // full-word write of settings two, then read of settings one
  sequence s_take_two;
    req && wb_we_i && wb_adr_i == 12'h248 && wb_sel_i == 4'hf ##1 wb_ack_o;
  endsequence
  sequence s_read_one;
    req && !wb_we_i && wb_adr_i == 12'h244 ##1 wb_ack_o;
  endsequence

  a_ack_follows: assert property (req |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_pulse: assert property (wb_ack_o && ce |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_data_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero while idle");
  a_write_lands: assert property (s_take_two |=> settings_two == $past(wb_dat_i, 2))
    else $error("settings two write not stored");
  a_read_one: assert property (s_read_one |-> wb_dat_o == {29'h0, settings_one})
    else $error("settings one read mismatch");
  a_speed_thresh: assert property (ce |=> thresholds.overspeed_percent ==
    8'h82 + 8'h0a * {5'h0, $past(settings_two.overspeed_threshold_select)})
    else $error("overspeed threshold mismatch");
  a_bemf_thresh: assert property (ce |=> thresholds.backemf_permille ==
    BEMF[$past(settings_two.backemf_threshold_select)])
    else $error("back-emf threshold mismatch");
  a_sat_follows: assert property (ce |=> saturation_indication ==
    $past(loop_saturation && settings_one.saturation_indication_enable))
    else $error("saturation indication mismatch");
endmodule

bind mfcr_regs mfcr_regs_asserts u_chk (.sys_clk, .rst, .ce, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .loop_saturation,
  .saturation_indication, .settings_one, .settings_two, .thresholds);

//--- mfcr_threshold_decode.sv
`timescale 1ns/100ps
// turns the two threshold codes into numeric thresholds
module mfcr_threshold_decode
(
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  input  wire logic                      ce,
  input  wire logic [2:0]                overspeed_threshold_select,
  input  wire logic [2:0]                backemf_threshold_select,
  output mfcr_pkg::mfcr_thresholds_t     thresholds
);

  mfcr_pkg::mfcr_thresholds_t next_thresholds;
  logic [7:0]                 overspeed_offset;

  // linear overspeed map, table for back-emf
  assign overspeed_offset = 8'(overspeed_threshold_select) * mfcr_pkg::OVERSPEED_STEP_PCT;
  assign next_thresholds.overspeed_percent =
    8'(mfcr_pkg::OVERSPEED_BASE_PCT + overspeed_offset); // [R7]
  assign next_thresholds.backemf_permille =
    mfcr_pkg::BACKEMF_PERMILLE[backemf_threshold_select]; // [R8]

  // registered so data outputs come from flops
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      thresholds <= {mfcr_pkg::OVERSPEED_BASE_PCT, mfcr_pkg::BACKEMF_PERMILLE[0]}; // code zero
    else if (ce)
      thresholds <= next_thresholds;
  end

endmodule

//--- motor_fault_config_regs_tb_top.sv
`timescale 1ns/100ps
// self-checking bench of the fault settings registers
module motor_fault_config_regs_tb_top;
  logic                         sys_clk, rst, ce, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic                         irq, loop_saturation, saturation_indication;
  logic [11:0]                  wb_adr_i;
  logic [3:0]                   wb_sel_i;
  logic [31:0]                  wb_dat_i, wb_dat_o, rd;
  logic [4:0]                   ev;
  mfcr_pkg::mfcr_settings_one_t settings_one;
  mfcr_pkg::mfcr_settings_two_t settings_two;
  mfcr_pkg::mfcr_thresholds_t   thresholds;
  int                           fails, checks_done;
  logic [31:0]                  bemf [8] = '{32'h190, 32'h1c2, 32'h1f4, 32'h226,
                                             32'h258, 32'h28a, 32'h2a3, 32'h2bc};

  mfcr_regs dut
  (
    .sys_clk, .rst, .ce, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .position_timeout_event(ev[0]), .position_frequency_event(ev[1]),
    .overspeed_event(ev[2]), .backemf_event(ev[3]), .motor_absent_event(ev[4]),
    .loop_saturation, .settings_one, .settings_two, .thresholds, .saturation_indication, .irq
  );

  // 10 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      $display("unexpected %s expected %h seen %h", nm, exp, got);
      fails++;
    end
  endtask

  // one classic wishbone cycle, read data lands in rd
  task automatic xfer(input logic we, input logic [11:0] a, input logic [3:0] s,
                      input logic [31:0] d);
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    // only the watchdog ends a wait for ack
    do
      @(posedge sys_clk);
    while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic pulse(input int b);
    @(posedge sys_clk);
    ev[b] <= 1'b1;
    @(posedge sys_clk);
    ev[b] <= 1'b0;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  task automatic t_reset();
    xfer(1'b0, 12'h248, 4'hf, 32'h0);
    check("two reset", 32'h0, rd);
    xfer(1'b0, 12'h244, 4'hf, 32'h0);
    check("one reset", 32'h0, rd);
    xfer(1'b0, 12'h300, 4'hf, 32'h0);
    check("unmapped", 32'h0, rd);
  endtask

  task automatic t_lanes();
    xfer(1'b1, 12'h248, 4'h8, 32'hf0ffffff);
    xfer(1'b0, 12'h248, 4'hf, 32'h0);
    check("top lane", 32'hf0000000, rd);
    check("lock ens", 32'h7, {settings_two[30:28]});
    xfer(1'b1, 12'h248, 4'h1, 32'h123456a5);
    xfer(1'b0, 12'h248, 4'hf, 32'h0);
    check("low lane", 32'hf00000a5, rd);
    xfer(1'b1, 12'h248, 4'hf, 32'h80000000);
    xfer(1'b0, 12'h248, 4'hf, 32'h0);
    check("reserved", 32'h80000000, rd);
  endtask

  // every code of both threshold fields
  task automatic t_codes();
    for (int i = 0; i < 8; i++)
    begin
      xfer(1'b1, 12'h248, 4'hf, {4'h0, 3'(i), 3'(7 - i), 22'h0});
      @(negedge sys_clk);
      check("speed thr", 32'h82 + 32'h0a * i, {24'h0, thresholds.overspeed_percent});
      check("bemf thr", bemf[7 - i], {22'h0, thresholds.backemf_permille});
    end
  endtask

  task automatic t_one();
    for (int b = 2; b >= 0; b--)
    begin
      xfer(1'b1, 12'h244, 4'h1, 32'h1 << b);
      xfer(1'b0, 12'h244, 4'hf, 32'h0);
      check("one rd", 32'h1 << b, rd);
      check("one out", 32'h1 << b, {29'h0, settings_one});
    end
    loop_saturation <= 1'b1;
    repeat (2) @(negedge sys_clk);
    check("sat on", 32'h1, {31'h0, saturation_indication});
    xfer(1'b0, 12'h280, 4'hf, 32'h0);
    check("sat status", 32'h20, rd);
    xfer(1'b1, 12'h244, 4'h1, 32'h0);
    @(negedge sys_clk);
    check("sat off", 32'h0, {31'h0, saturation_indication});
    // drop the loop flag and clear its sticky status for later tests
    @(posedge sys_clk);
    loop_saturation <= 1'b0;
    xfer(1'b1, 12'h284, 4'h1, 32'h20);
    xfer(1'b0, 12'h280, 4'hf, 32'h0);
    check("sat clear", 32'h0, rd);
  endtask

  // each detector gated by its enable, raised, masked and cleared
  task automatic t_irq();
    for (int k = 0; k < 5; k++)
    begin
      xfer(1'b1, 12'h288, 4'h1, 32'h1f);
      xfer(1'b1, (k < 2) ? 12'h244 : 12'h248, 4'hf, 32'h1 << ((k < 2) ? 2 - k : 32 - k));
      pulse(k);
      check("irq set", 32'h1, {31'h0, irq});
      xfer(1'b0, 12'h280, 4'hf, 32'h0);
      check("status", 32'h1 << k, rd);
      xfer(1'b1, 12'h288, 4'h1, 32'h0);
      @(negedge sys_clk);
      check("irq mask", 32'h0, {31'h0, irq});
      xfer(1'b1, 12'h284, 4'h1, 32'h1f);
      xfer(1'b1, (k < 2) ? 12'h244 : 12'h248, 4'hf, 32'h0);
      pulse(k);
      xfer(1'b0, 12'h280, 4'hf, 32'h0);
      check("gated", 32'h0, rd);
    end
  endtask

  // an event seen only while ce is low is not taken
  task automatic t_hold();
    xfer(1'b1, 12'h244, 4'h1, 32'h4);
    xfer(1'b1, 12'h288, 4'h1, 32'h1);
    ce <= 1'b0;
    ev[0] <= 1'b1;
    @(posedge sys_clk);
    ev[0] <= 1'b0;
    @(posedge sys_clk);
    ce <= 1'b1;
    @(negedge sys_clk);
    check("frozen irq", 32'h0, {31'h0, irq});
    xfer(1'b0, 12'h280, 4'hf, 32'h0);
    check("frozen status", 32'h0, rd);
    pulse(0);
    check("live irq", 32'h1, {31'h0, irq});
    xfer(1'b1, 12'h244, 4'h1, 32'h0);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // main sequence
  initial
  begin
    {rst, ce} = 2'h3;
    {wb_cyc_i, wb_stb_i, wb_we_i, loop_saturation} = 4'h0;
    {wb_adr_i, wb_sel_i, wb_dat_i, ev} = '0;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_lanes();
    t_codes();
    t_one();
    t_irq();
    t_hold();
    summarize();
  end

  // watchdog
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    summarize();
  end
endmodule
